// [pcs_pkg.sv]
// Package for the five-channel power sequencer and fault logic.
// Assumes a single 10 MHz clock domain; shared constants live here.
package pcs_pkg;
	// ----------------------------------------
	// Timing and reference levels
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned DISCHARGE_NS      = 300;
	localparam int unsigned DISCHARGE_CYC     =
		(DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PERIOD_CYC        = 20;
	localparam int unsigned DUTY_MAX_PCT      = 80;
	localparam int unsigned DUTY_MAX_CYC      =
		(PERIOD_CYC * DUTY_MAX_PCT) / 100;
	localparam int unsigned FAULT_OSC_CYC     = 100000;
	localparam int unsigned SOFT_OSC_CYC      = 4096;
	localparam int unsigned BUCK_DELAY_CYC    = 1024;
	localparam int unsigned REF_W             = 12;
	localparam logic [REF_W-1:0] REF_FULL     = 12'hFFF;
	localparam logic [REF_W-1:0] REF_ZERO     = 12'h000;

	// ----------------------------------------
	// Grouped signals
	// ----------------------------------------
	typedef struct packed {
		logic boost;
		logic buck;
		logic [2:0] aux;
	} pcs_chan_t;

	typedef enum logic [1:0] {
		PCS_OFF,
		PCS_WAIT,
		PCS_RAMP,
		PCS_RUN
	} pcs_state_t;
endpackage

// [pcs_sequencer.sv]
// Sequencing, soft-start, aux PWM gate shaping and latching fault timer.
// Assumes the analog loops supply level indications on i_mclk; these and
// the pins alike are double-registered here before use.
//
// Notes on behaviour
// [RL1] Aux gate goes high each cycle start, low on ramp-over-comp or limit.
// [RL2] Aux gate may stay high for at most 80 percent of the period.
// [RL3] Buck and aux channels stay off until boost output regulates.
// [RL4] Fault persisting 100000 oscillator cycles latches all channels off.
// [RL5] Fault latch clears only by boost enable low or power cycling.
// [RL6] Fault indications ignored during a channel's soft-start ramp.
// [RL7] Reference enabled only with buck enable high and buck above 2.5 V.
// [RL8] Ramp reaching reference fires a 300 ns discharge one-shot.
// [RL9] Startup oscillator drives boost switch until boost output hits 2.5 V.
// [RL10] Buck and aux references ramp zero to full over 4096 cycles.
// [RL11] Boost channel has no soft-start, full reference at once.
// [RL12] Each channel active only while its enable input is high.
// [RL13] Buck soft-start begins 1024 cycles after boost regulation.
// [RL14] Buck good output pulled low while buck output regulates.
// [RL15] Aux gates forced low in shutdown and thermal limit.
// [RL16] Fault counter restarts when a fault clears before threshold.
`timescale 1ns/1ns
module pcs_sequencer
	import pcs_pkg::*;
#(
	parameter int unsigned FAULT_CYC = FAULT_OSC_CYC,
	parameter int unsigned SOFT_CYC  = SOFT_OSC_CYC,
	parameter int unsigned DELAY_CYC = BUCK_DELAY_CYC
) (
	input  wire logic            i_mclk,
	input  wire logic            i_rstn,
	input  wire logic            i_ce,
	input  wire pcs_chan_t       i_enable,
	input  wire logic            i_boost_reg,
	input  wire logic            i_boost_above_2v5,
	input  wire logic            i_buck_above_2v5,
	input  wire pcs_chan_t       i_in_reg,
	input  wire logic            i_timing_ramp_pin,
	input  wire logic [2:0]      i_ramp_over_comp,
	input  wire logic            i_startup_osc,
	input  wire logic            i_thermal_limit,
	output logic [2:0]           o_aux_gate_drive,
	output logic                 o_osc_discharge,
	output logic                 o_startup_drive,
	output logic                 o_ref_enable,
	output logic                 o_buck_good_n_oe,
	output logic                 o_fault_latched,
	output pcs_chan_t            o_chan_active,
	output logic [4*REF_W-1:0]   o_soft_ref
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int SW = 19;
	logic [SW-1:0] sync1, sync2;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (i_ce) begin
			sync1 <= {i_enable, i_boost_reg, i_boost_above_2v5,
				i_buck_above_2v5, i_in_reg, i_timing_ramp_pin,
				i_ramp_over_comp, i_startup_osc, i_thermal_limit};
			sync2 <= sync1;
		end
	end
	pcs_chan_t  en, inreg;
	logic       boost_reg, boost_2v5, buck_2v5, ramp_hit, su_osc, tlim;
	logic [2:0] over_comp;
	assign {en, boost_reg, boost_2v5, buck_2v5, inreg, ramp_hit,
		over_comp, su_osc, tlim} = sync2;

	// ----------------------------------------
	// Master oscillator one-shot
	// ----------------------------------------
	logic [1:0] dis_cnt;
	logic       cyc_start;
	logic [4:0] phase;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			dis_cnt   <= '0;
			cyc_start <= 1'b0;
		end else if (i_ce) begin
			cyc_start <= 1'b0;
			if (dis_cnt != 2'h0) begin
				dis_cnt <= dis_cnt - 2'h1;
				cyc_start <= (dis_cnt == 2'h1); // RL8
			end else if (ramp_hit) begin
				dis_cnt <= 2'(DISCHARGE_CYC); // RL8
			end
		end
	end

	// Phase counts cycles since the start; bounds the gate pulse width
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn)
			phase <= '0;
		else if (i_ce) begin
			if (cyc_start)
				phase <= '0;
			else if (phase != 5'h1F)
				phase <= phase + 5'h1;
		end
	end

	// ----------------------------------------
	// Sequencing and soft-start
	// ----------------------------------------
	logic       latched, kill;
	logic [10:0] dly;
	logic       buck_go;
	logic [REF_W:0] ramp [4];
	logic [3:0] ramping;
	logic [3:0] req;
	assign kill = latched | !en.boost;
	// Order: 0 buck, 1..3 aux
	assign req = {en.aux, en.buck} & {4{boost_reg & !kill}}; // RL3 RL12

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			dly     <= '0;
			buck_go <= 1'b0;
		end else if (i_ce) begin
			if (!boost_reg || kill) begin
				dly     <= '0;
				buck_go <= 1'b0;
			end else if (cyc_start && !buck_go) begin
				dly     <= dly + 11'h1;
				buck_go <= (dly == 11'(DELAY_CYC - 1)); // RL13
			end
		end
	end

	// Ramp counts oscillator cycles; reference is the low REF_W bits of the count while ramping, REF_FULL once it ends
	for (genvar c = 0; c < 4; c++) begin : g_soft
		logic go;
		assign go = req[c] & (c == 0 ? buck_go : 1'b1);
		always_ff @(posedge i_mclk or negedge i_rstn) begin
			if (!i_rstn)
				ramp[c] <= '0;
			else if (i_ce) begin
				if (!go)
					ramp[c] <= '0; // RL10
				else if (cyc_start && ramp[c] != (REF_W+1)'(SOFT_CYC))
					ramp[c] <= ramp[c] + 1'b1; // RL10
			end
		end
		assign ramping[c] = go & (ramp[c] != (REF_W+1)'(SOFT_CYC));
		always_ff @(posedge i_mclk or negedge i_rstn) begin
			if (!i_rstn)
				o_soft_ref[c*REF_W +: REF_W] <= REF_ZERO;
			else if (i_ce)
				o_soft_ref[c*REF_W +: REF_W] <= ramping[c] ?
					ramp[c][REF_W-1:0] : (go ? REF_FULL : REF_ZERO);
		end
	end

	// ----------------------------------------
	// Fault timer
	// ----------------------------------------
	logic [16:0] fcnt;
	logic        faulted;
	// Boost has no soft-start, so it is watched as soon as it regulates once
	logic        boost_seen;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn)
			boost_seen <= 1'b0;
		else if (i_ce)
			boost_seen <= en.boost & !latched & (boost_seen | boost_reg);
	end
	assign faulted = (boost_seen & !inreg.boost)
		| |(~{inreg.aux, inreg.buck} & {en.aux, en.buck & buck_go}
			& req & ~ramping); // RL6

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			fcnt    <= '0;
			latched <= 1'b0;
		end else if (i_ce) begin
			if (!en.boost) begin
				fcnt    <= '0;
				latched <= 1'b0; // RL5
			end else if (!faulted) begin
				fcnt <= '0; // RL16
			end else if (cyc_start && !latched) begin
				fcnt <= fcnt + 17'h1;
				if (fcnt == 17'(FAULT_CYC - 1))
					latched <= 1'b1; // RL4
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_aux_gate_drive <= '0;
			o_osc_discharge  <= 1'b0;
			o_startup_drive  <= 1'b0;
			o_ref_enable     <= 1'b0;
			o_buck_good_n_oe <= 1'b0;
			o_fault_latched  <= 1'b0;
			o_chan_active    <= '0;
		end else if (i_ce) begin
			for (int a = 0; a < 3; a++) begin
				if (!req[a+1] || tlim)
					o_aux_gate_drive[a] <= 1'b0; // RL15
				else if (cyc_start)
					o_aux_gate_drive[a] <= 1'b1; // RL1
				else if (over_comp[a] ||
					phase >= 5'(DUTY_MAX_CYC - 1))
					o_aux_gate_drive[a] <= 1'b0; // RL1 RL2
			end
			// Switch closes on the hit itself and stays for three clocks
			o_osc_discharge  <= (dis_cnt == 2'h0) ? ramp_hit
				: (dis_cnt != 2'h1); // RL8
			o_startup_drive  <= en.boost & !latched & !boost_2v5
				& su_osc; // RL9
			o_ref_enable     <= en.buck & buck_2v5; // RL7
			o_buck_good_n_oe <= req[0] & buck_go & inreg.buck; // RL14
			o_fault_latched  <= latched;
			o_chan_active.boost <= en.boost & !latched; // RL11 RL12
			o_chan_active.buck  <= req[0] & buck_go;
			o_chan_active.aux   <= req[3:1];
		end
	end
endmodule

// [pcs_analog_model.sv]
// Far-side model: oscillator timing capacitor and aux ramp comparators.
// Assumes the sequencer discharge output closes the oscillator loop.
`timescale 1ns/1ns
module pcs_analog_model (
	input  wire logic        i_mclk,
	input  wire logic        i_dis,
	input  wire logic [23:0] i_comp,
	output logic             o_hit,
	output logic [2:0]       o_over
);
	logic [7:0] phase;
	initial {phase, o_hit, o_over} = 12'h000;
	// Ramp restarts only while the switch is closed, as the real cap does
	always @(negedge i_mclk) begin
		phase <= i_dis ? 8'h00 : phase + 8'h01;
		o_hit <= (phase >= 8'h0D) && !i_dis;
		for (int i = 0; i < 3; i++)
			o_over[i] <= phase >= i_comp[8*i+:8];
	end
endmodule

// [pcs_seq_asserts.sv]
// Port relations of the sequencer: gating, timing and fault latch.
// Assumes i_ce high, so a pin reaches an output three cycles later.
`timescale 1ns/1ns
module pcs_seq_asserts
	import pcs_pkg::*;
(
	input wire logic       i_mclk,
	input wire logic       i_rstn,
	input wire pcs_chan_t  i_enable,
	input wire logic       i_boost_above_2v5,
	input wire pcs_chan_t  i_in_reg,
	input wire logic       i_thermal_limit,
	input wire logic [2:0] o_aux_gate_drive,
	input wire logic       o_osc_discharge,
	input wire logic       o_startup_drive,
	input wire logic       o_buck_good_n_oe,
	input wire logic       o_fault_latched,
	input wire pcs_chan_t  o_chan_active
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	AST_THERM: assert property (i_thermal_limit [*4] |->
		o_aux_gate_drive == 3'h0) else $error("gate on in thermal limit");
	AST_BUCK: assert property (!i_enable.boost [*4] |->
		o_chan_active == 5'h00) else $error("channel on, boost off");
	AST_OFF: assert property (!i_enable.aux[0] [*4] |->
		!o_aux_gate_drive[0]) else $error("gate on while disabled");
	AST_LATCH: assert property (o_fault_latched [*2] |->
		o_chan_active == 5'h00) else $error("channel on while latched");
	AST_START: assert property (o_startup_drive |->
		!$past(i_boost_above_2v5, 3)) else $error("startup drive late");
	AST_GOOD: assert property (o_buck_good_n_oe |->
		$past(i_in_reg.buck, 3)) else $error("buck good while faulted");
	AST_DIS: assert property ($rose(o_osc_discharge) |->
		o_osc_discharge [*3] ##1 !o_osc_discharge) else $error("bad shot");
	AST_DUTY: assert property ($rose(o_aux_gate_drive[0]) |->
		##[1:17] !o_aux_gate_drive[0]) else $error("gate past limit");
endmodule
bind pcs_sequencer pcs_seq_asserts u_chk (.i_mclk, .i_rstn, .i_enable,
	.i_boost_above_2v5, .i_in_reg, .i_thermal_limit, .o_aux_gate_drive,
	.o_osc_discharge, .o_startup_drive, .o_buck_good_n_oe,
	.o_fault_latched, .o_chan_active);

// [pcs_sequencer_bench.sv]
// Directed bench: sequencing, aux gate timing, thermal and fault latch.
// Assumes pcs_analog_model stands in for the analog loops.
`timescale 1ns/1ns
module pcs_sequencer_bench
	import pcs_pkg::*;
();
	logic        mclk = 1'h0;
	logic        rstn, breg, therm, hit, dis, sd, refe, bg, flt;
	pcs_chan_t   en, inreg, act;
	logic [2:0]  over, gate;
	logic [23:0] comp;
	logic [47:0] sref;
	int          failures, total_checks, cyc, w0, w1;
	initial forever #50 mclk = ~mclk;
	pcs_sequencer #(.FAULT_CYC(20), .SOFT_CYC(16), .DELAY_CYC(8)) uut (
		.i_mclk(mclk), .i_rstn(rstn), .i_ce(1'h1), .i_enable(en),
		.i_boost_reg(breg), .i_boost_above_2v5(breg),
		.i_buck_above_2v5(inreg.buck), .i_in_reg(inreg),
		.i_timing_ramp_pin(hit), .i_ramp_over_comp(over),
		.i_startup_osc(1'h1), .i_thermal_limit(therm),
		.o_aux_gate_drive(gate), .o_osc_discharge(dis),
		.o_startup_drive(sd), .o_ref_enable(refe),
		.o_buck_good_n_oe(bg), .o_fault_latched(flt),
		.o_chan_active(act), .o_soft_ref(sref));
	pcs_analog_model u_model (.i_mclk(mclk), .i_dis(dis), .i_comp(comp),
		.o_hit(hit), .o_over(over));
	task automatic chk(input string n, input logic [47:0] e, g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Aux 0 fault held for n cycles, then cleared
	task automatic drop(input int n);
		inreg.aux[0] = 1'h0;
		idle(n);
		inreg.aux[0] = 1'h1;
		idle(20);
	endtask
	task automatic width(input int ch, output int w);
		@(posedge gate[ch]);
		w = 0;
		while (gate[ch] === 1'h1 && w < 40) begin
			@(negedge mclk);
			w++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Whole run needs about 3300 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		{rstn, breg, therm, en, inreg} = 13'h0000;
		comp = 24'h63_0563;
		idle(4);
		rstn = 1'h1;
		en = 5'h1F;
		inreg = 5'h1F;
		idle(60);
		chk("pre_reg", 5'h10, act);
		chk("startup", 1, sd);
		breg = 1'h1;
		idle(100);
		chk("buck_wait", 13'h0000, {act.buck, sref[11:0]});
		idle(800);
		chk("all_on", 5'h1F, act);
		chk("ref_full", {4{REF_FULL}}, sref);
		chk("pins", 3'h3, {sd, refe, bg});
		$display("test sequence done");
		width(0, w0);
		width(1, w1);
		chk("duty", 1, w0 >= DUTY_MAX_CYC);
		chk("comp", 1, w1 < w0);
		therm = 1'h1;
		idle(6);
		chk("therm", 3'h0, gate);
		therm = 1'h0;
		$display("test gate done");
		drop(250);
		drop(250);
		chk("brief", 0, flt);
		drop(600);
		chk("latch", 6'h20, {flt, act});
		idle(40);
		chk("held", 1, flt);
		en.boost = 1'h0;
		idle(10);
		en.boost = 1'h1;
		inreg.aux[0] = 1'h0;
		idle(500);
		chk("soft_skip", 0, flt);
		idle(600);
		chk("relatch", 1, flt);
		$display("test fault done");
		report_and_stop();
	end
endmodule
